// [rtl/lsu_params.svh]
`ifndef LSU_PARAMS_SVH
`define LSU_PARAMS_SVH
`define OPC_HI 31
`define OPC_LO 26
`define BASE_HI 25
`define BASE_LO 21
`define TGT_HI 20
`define TGT_LO 16
`define OFS_HI 15
`define OFS_LO 0
`define OPC_LOAD_BYTE_SIGNED 6'h20
`define OPC_LOAD_HALF_SIGNED 6'h21
`define OPC_LOAD_WORD_SEXT 6'h23
`define OPC_LOAD_BYTE_ZERO_EXT 6'h24
`define OPC_LOAD_HALF_ZERO_EXT 6'h25
`define OPC_LOAD_DOUBLE 6'h37
`define OPC_STORE_BYTE 6'h28
`define OPC_STORE_HALF 6'h29
`define OPC_STORE_WORD 6'h2b
`define OPC_STORE_DOUBLE 6'h3f
`define DELAY_SLOT_CYCLES 1
`endif

// [rtl/lsu_pkg.sv]
package lsu_pkg;
  typedef enum logic [2:0] {
    SZ_BYTE = 3'h0, SZ_HALF = 3'h1, SZ_TRIPLE = 3'h2, SZ_WORD = 3'h3,
    SZ_FIVE = 3'h4, SZ_SIX = 3'h5, SZ_SEVEN = 3'h6, SZ_DOUBLE = 3'h7
  } size_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0, ST_STALL = 2'h1
  } stall_state_t;
  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [63:0] base;
  } issue_t;
  typedef struct packed {
    logic valid;
    logic is_load;
    logic [63:0] addr;
    logic [7:0] lanes;
    logic addr_err;
  } access_t;
endpackage

// [rtl/load_store_byte_lane_unit.sv]
`timescale 1ns/1ps
`include "lsu_params.svh"
// Function
// - address is base plus sign-extended 16-bit offset only.
// - instruction reading a just-loaded register other than register 0 is stalled by interlock.
// - delay penalty is one cycle after load and one after store.
// - cache access right after a store is held by interlock.
// - opcode fixes 3-bit size code, byte 0 up to doubleword 7.
// - effective address names the lowest-order byte of the field.
// - byte lanes follow size and address bits 2..0 for common sizes.
// - odd sizes use their listed lane positions only.
// - any unlisted size and address pairing raises address error.
// - unsigned byte load is zero-extended.
// - signed halfword load is sign-extended.
// - instruction is 32 bits; op, base, target, offset fields fixed.
// - word load in 64-bit mode is sign-extended to 64 bits.
module load_store_byte_lane_unit #(
  parameter int XLEN = 64
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire lsu_pkg::issue_t issue_i,
  input wire logic [4:0] src_a_i,
  input wire logic [4:0] src_b_i,
  input wire logic mode64_i,
  input wire logic [63:0] cache_rdata_i,
  output lsu_pkg::access_t access_o,
  output logic [63:0] load_data_o,
  output logic [4:0] load_reg_o,
  output logic load_we_o,
  output logic stall_o
);

////////////////////////////////////////////////////////////////////////////
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

////////////////////////////////////////////////////////////////////////////
  // decode
  logic [5:0] opc;
  logic [4:0] tgt;
  logic [63:0] ofs_sx;
  logic [63:0] ea;
  logic is_load, is_store, is_signed, known;
  lsu_pkg::size_t size;
  assign opc = issue_i.instr[`OPC_HI:`OPC_LO];
  assign tgt = issue_i.instr[`TGT_HI:`TGT_LO];
  assign ofs_sx = {{48{issue_i.instr[`OFS_HI]}},
                   issue_i.instr[`OFS_HI:`OFS_LO]};
  assign ea = issue_i.base + ofs_sx;

  always_comb begin
    is_load = 1'b1;
    is_store = 1'b0;
    is_signed = 1'b0;
    known = 1'b1;
    size = lsu_pkg::SZ_BYTE;
    case (opc)
      `OPC_LOAD_BYTE_SIGNED: is_signed = 1'b1;
      `OPC_LOAD_BYTE_ZERO_EXT: is_signed = 1'b0;
      `OPC_LOAD_HALF_SIGNED: begin
        size = lsu_pkg::SZ_HALF;
        is_signed = 1'b1;
      end
      `OPC_LOAD_HALF_ZERO_EXT: size = lsu_pkg::SZ_HALF;
      `OPC_LOAD_WORD_SEXT: begin
        size = lsu_pkg::SZ_WORD;
        is_signed = 1'b1;
      end
      `OPC_LOAD_DOUBLE: size = lsu_pkg::SZ_DOUBLE;
      `OPC_STORE_BYTE: begin
        is_load = 1'b0;
        is_store = 1'b1;
      end
      `OPC_STORE_HALF: begin
        is_load = 1'b0;
        is_store = 1'b1;
        size = lsu_pkg::SZ_HALF;
      end
      `OPC_STORE_WORD: begin
        is_load = 1'b0;
        is_store = 1'b1;
        size = lsu_pkg::SZ_WORD;
      end
      `OPC_STORE_DOUBLE: begin
        is_load = 1'b0;
        is_store = 1'b1;
        size = lsu_pkg::SZ_DOUBLE;
      end
      default: begin
        is_load = 1'b0;
        known = 1'b0;
      end
    endcase
  end

////////////////////////////////////////////////////////////////////////////
  // lane map; lane ea[2:0] is the addressed low-order byte
  logic [7:0] lanes;
  logic legal;
  logic [2:0] a;
  assign a = ea[2:0];
  always_comb begin
    legal = 1'b1;
    lanes = 8'h00;
    case (size)
      lsu_pkg::SZ_BYTE: lanes = 8'h01 << a;
      lsu_pkg::SZ_HALF: begin
        legal = ~a[0];
        lanes = 8'h03 << a;
      end
      lsu_pkg::SZ_TRIPLE: begin
        legal = ~a[1];
        lanes = 8'h07 << a;
      end
      lsu_pkg::SZ_WORD: begin
        legal = (a[1:0] == 2'h0);
        lanes = 8'h0f << a;
      end
      lsu_pkg::SZ_FIVE: begin
        legal = (a == 3'h0) || (a == 3'h3);
        lanes = 8'h1f << a;
      end
      lsu_pkg::SZ_SIX: begin
        legal = (a == 3'h0) || (a == 3'h2);
        lanes = 8'h3f << a;
      end
      lsu_pkg::SZ_SEVEN: begin
        legal = (a == 3'h0) || (a == 3'h1);
        lanes = 8'h7f << a;
      end
      default: begin
        legal = (a == 3'h0);
        lanes = 8'hff;
      end
    endcase
    if (!legal) lanes = 8'h00;
  end

////////////////////////////////////////////////////////////////////////////
  // interlock: a load whose nonzero target is read next, or a cache user after a store
  logic prev_load_r, prev_store_r;
  logic [4:0] prev_tgt_r;
  logic hazard;
  lsu_pkg::stall_state_t st_r;
  assign hazard = issue_i.valid && st_r == lsu_pkg::ST_RUN && (
    (prev_load_r && prev_tgt_r != 5'h00 &&
     (src_a_i == prev_tgt_r || src_b_i == prev_tgt_r)) ||
    (prev_store_r && (is_load || is_store)));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= lsu_pkg::ST_RUN;
      stall_o <= 1'b0;
    end else begin
      // exactly one held cycle per hazard
      case (st_r)
        lsu_pkg::ST_RUN: st_r <= hazard ? lsu_pkg::ST_STALL : lsu_pkg::ST_RUN;
        lsu_pkg::ST_STALL: st_r <= lsu_pkg::ST_RUN;
        default: st_r <= lsu_pkg::ST_RUN;
      endcase
      stall_o <= hazard;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_load_r <= 1'b0;
      prev_store_r <= 1'b0;
      prev_tgt_r <= 5'h00;
    end else if (!hazard) begin
      prev_load_r <= issue_i.valid && is_load && legal;
      prev_store_r <= issue_i.valid && is_store && legal;
      prev_tgt_r <= tgt;
    end else begin
      prev_load_r <= 1'b0;
      prev_store_r <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // access issue to the cache
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      access_o <= '0;
    end else begin
      access_o.valid <= issue_i.valid && known && !hazard && legal;
      access_o.is_load <= is_load;
      access_o.addr <= ea;
      access_o.lanes <= lanes;
      access_o.addr_err <= issue_i.valid && known && !hazard
                           && !legal;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // load return: data arrives one cycle after the access is issued
  logic ld_pend_r, ld_sgn_r, ld_m64_r;
  logic [2:0] ld_sz_r, ld_a_r;
  logic [4:0] ld_tgt_r;
  logic [63:0] shifted, ext;
  assign shifted = cache_rdata_i >> {ld_a_r, 3'h0};
  always_comb begin
    ext = shifted;
    case (ld_sz_r)
      3'h0: ext = {{56{ld_sgn_r & shifted[7]}}, shifted[7:0]};
      3'h1: ext = {{48{ld_sgn_r & shifted[15]}}, shifted[15:0]};
      3'h3: ext = {{32{ld_sgn_r & shifted[31]}}, shifted[31:0]};
      default: ext = shifted;
    endcase
    if (!ld_m64_r) ext[63:32] = {32{ext[31]}};
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ld_pend_r <= 1'b0;
      ld_sgn_r <= 1'b0;
      ld_m64_r <= 1'b0;
      ld_sz_r <= 3'h0;
      ld_a_r <= 3'h0;
      ld_tgt_r <= 5'h00;
      load_we_o <= 1'b0;
      load_reg_o <= 5'h00;
      load_data_o <= 64'h0;
    end else begin
      ld_pend_r <= issue_i.valid && is_load && legal && !hazard;
      ld_sgn_r <= is_signed;
      ld_m64_r <= mode64_i;
      ld_sz_r <= size;
      ld_a_r <= a;
      ld_tgt_r <= tgt;
      load_we_o <= ld_pend_r;
      load_reg_o <= ld_tgt_r;
      load_data_o <= ext;
    end
  end

endmodule

// [test/lsu_assertions.sv]
`timescale 1ns/1ps
module lsu_assertions (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire lsu_pkg::issue_t issue_i,
  input wire lsu_pkg::access_t access_o,
  input wire logic [63:0] load_data_o,
  input wire logic [4:0] load_reg_o,
  input wire logic load_we_o,
  input wire logic stall_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] ln;
  logic ok;
  assign ln = access_o.lanes >> access_o.addr[2:0];
  assign ok = access_o.valid && !access_o.addr_err;
  a_addr_sum: assert property (
    access_o.valid |-> access_o.addr == $past(issue_i.base)
    + {{48{$past(issue_i.instr[15])}}, $past(issue_i.instr[15:0])})
    else $error("address sum wrong");
  a_err_no_lanes: assert property (
    access_o.addr_err |-> access_o.lanes == 8'h00) else $error("lanes on err");
  a_lanes_low: assert property (
    ok |-> ln[0] && (ln << access_o.addr[2:0]) == access_o.lanes)
    else $error("lanes not at address");
  a_lanes_run: assert property (
    ok |-> (ln & (ln + 8'h01)) == 8'h00) else $error("lanes not contiguous");
  a_kind_op: assert property (
    access_o.valid |-> access_o.is_load == !$past(issue_i.instr[29]))
    else $error("load flag wrong");
  a_we_cause: assert property (
    load_we_o |-> $past(ok && access_o.is_load)) else $error("stray write");
  a_we_due: assert property (
    ok && access_o.is_load |=> load_we_o) else $error("write missing");
  a_target_reg: assert property (
    load_we_o |-> load_reg_o == $past(issue_i.instr[20:16], 2))
    else $error("target wrong");
  a_zext_byte: assert property (
    load_we_o && $past(issue_i.instr[31:26], 2) == 6'h24
    |-> load_data_o[63:8] == 56'h0) else $error("byte not zero extended");
  a_sext_half: assert property (
    load_we_o && $past(issue_i.instr[31:26], 2) == 6'h21
    |-> load_data_o[63:16] == {48{load_data_o[15]}}) else $error("half ext");
  a_sext_word: assert property (
    load_we_o && $past(issue_i.instr[31:26], 2) == 6'h23
    |-> load_data_o[63:32] == {32{load_data_o[31]}}) else $error("word ext");
  a_stall_drop: assert property (
    stall_o |-> !access_o.valid) else $error("access during stall");
  c_stall: cover property (stall_o);
  c_err: cover property (access_o.addr_err);
  c_load: cover property (load_we_o);
endmodule

// [test/cache_model.sv]
`timescale 1ns/1ps
module cache_model (
  input wire logic clock_i,
  input wire lsu_pkg::access_t access_i,
  output logic [63:0] rdata_o
);
  lsu_pkg::access_t last_r = '0;
  logic [63:0] noise_r = 64'h0;
  // data held two cycles; otherwise churns so stale data never matches
  always_ff @(posedge clock_i) begin
    last_r <= access_i;
    noise_r <= noise_r + 64'h0123_4567_89ab_cdef;
  end
  always_comb begin
    rdata_o = noise_r;
    if (access_i.valid && access_i.is_load)
      rdata_o = {access_i.addr[34:3], ~access_i.addr[34:3]};
    else if (last_r.valid && last_r.is_load)
      rdata_o = {last_r.addr[34:3], ~last_r.addr[34:3]};
  end
endmodule

// [test/tb_load_store_byte_lane_unit.sv]
`timescale 1ns/1ps
module tb_load_store_byte_lane_unit;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  lsu_pkg::issue_t issue_i = '0;
  logic [4:0] src_a_i = 5'h00;
  logic [4:0] src_b_i = 5'h00;
  logic mode64_i = 1'b1;
  logic [63:0] cache_rdata_i;
  lsu_pkg::access_t access_o;
  logic [63:0] load_data_o;
  logic [4:0] load_reg_o;
  logic load_we_o;
  logic stall_o;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  logic [5:0] ops [10] = '{6'h20, 6'h21, 6'h23, 6'h24, 6'h25, 6'h37,
    6'h28, 6'h29, 6'h2b, 6'h3f};
  always #25 clock_i = ~clock_i;
  load_store_byte_lane_unit i_load_store_byte_lane_unit (.clock_i, .nrst_i,
    .issue_i, .src_a_i, .src_b_i, .mode64_i, .cache_rdata_i, .access_o,
    .load_data_o, .load_reg_o, .load_we_o, .stall_o);
  cache_model i_cache_model (.clock_i, .access_i(access_o),
    .rdata_o(cache_rdata_i));
  task chk(string n, logic [63:0] s, logic [63:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      give_verdict;
    end
  end
  function automatic logic [63:0] exp_data(logic [5:0] op, logic [63:0] a);
    logic [63:0] d;
    d = {a[34:3], ~a[34:3]} >> {a[2:0], 3'h0};
    case (op[1:0])
      2'h0: d = op[2] ? {56'h0, d[7:0]} : {{56{d[7]}}, d[7:0]};
      2'h1: d = op[2] ? {48'h0, d[15:0]} : {{48{d[15]}}, d[15:0]};
      2'h3: if (!op[4]) d = {{32{d[31]}}, d[31:0]};
      default: d = d;
    endcase
    return d;
  endfunction
  // the unsigned loads reuse the size of their signed twins
  function automatic logic [2:0] op_size(logic [5:0] op);
    if (op == 6'h24) return 3'h0;
    if (op == 6'h25) return 3'h1;
    return op[2:0];
  endfunction
  // two idle slots after each access keep the stream free of interlocks
  task automatic do_op(logic [5:0] op, logic [4:0] rt, logic [15:0] f,
    logic [63:0] b);
    logic [63:0] a;
    logic [8:0] m;
    logic e;
    logic [2:0] sz;
    a = b + {{48{f[15]}}, f};
    sz = op_size(op);
    m = ((9'h1 << (sz + 4'h1)) - 9'h1) << a[2:0];
    e = |(a[2:0] & sz);
    issue_i <= '{1'b1, {op, 5'h3, rt, f}, b};
    src_a_i <= 5'($urandom);
    mode64_i <= op[2:0] == 3'h7 ? 1'b1 : 1'($urandom);
    @(posedge clock_i);
    issue_i.valid <= 1'b0;
    #1 chk("addr", access_o.addr, a);
    chk("valid", access_o.valid, !e);
    chk("err", access_o.addr_err, e);
    chk("lanes", access_o.lanes, e ? 8'h00 : m[7:0]);
    chk("is_load", access_o.is_load, !op[3]);
    @(posedge clock_i);
    #1 chk("we", load_we_o, !op[3] && !e);
    if (load_we_o === 1'b1) begin
      chk("reg", load_reg_o, rt);
      chk("data", load_data_o, exp_data(op, a));
    end
    @(posedge clock_i);
  endtask
  task automatic hz(logic [5:0] op1, logic [5:0] op2, logic [4:0] s);
    issue_i <= '{1'b1, {op1, 5'h1, 5'h5, 16'h0}, 64'h100};
    @(posedge clock_i);
    issue_i.instr[31:26] <= op2;
    src_b_i <= s;
    @(posedge clock_i);
    #1 chk("drop", access_o.valid, 1'b0);
    chk("stall", stall_o, 1'b1);
    @(posedge clock_i);
    issue_i.valid <= 1'b0;
    src_b_i <= 5'h00;
    #1 chk("retake", access_o.valid, 1'b1);
    chk("unstall", stall_o, 1'b0);
    repeat (2) @(posedge clock_i);
  endtask
  initial begin
    logic [15:0] f;
    logic [63:0] b;
    void'($urandom(45461));
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    do_op(6'h37, 5'h1, 16'hfff8, 64'h8);
    do_op(6'h20, 5'h2, 16'h8000, 64'h8003);
    hz(6'h23, 6'h21, 5'h5);
    hz(6'h2b, 6'h20, 5'h0);
    hz(6'h28, 6'h3f, 5'h0);
    repeat (60) begin
      f = 16'($urandom);
      b = {$urandom, $urandom};
      if ($urandom % 2) b[2:0] = -f[2:0];
      do_op(ops[$urandom % 10], 5'($urandom), f, b);
    end
    give_verdict;
  end
endmodule
bind load_store_byte_lane_unit lsu_assertions i_lsu_assertions (.clock_i,
  .nrst_i, .issue_i, .access_o, .load_data_o, .load_reg_o, .load_we_o,
  .stall_o);
